// [hdl/fid_host.v]
// Summary of operation
// R01: host sends each instruction as full byte sequence with short gaps
// R02: invalid sequence or long gap drops device back to read mode
// R03: each coded instruction opens with AA at 555 then 55 at AAA; host sends reset, bypass program/exit and add-sector codes without them
// R04: upper address lines are zero; sector select held high on each write
// R05: main selects route to primary flash, boot selects to secondary
// R06: device powers up in read mode with nothing pending
// R07: host holds selects low and write strobe high out of reset
// R08: plain reads outside instructions return memory contents
// R09: identifier read is three writes then read at A6,A1,A0 = 0,0,1
// R10: protection read is three writes then read at A6,A1,A0 = 0,1,0
// R11: status bits may be read any number of times while busy
// R12: poll bit reads inverse of programmed bit 7 until done
// R13: polling valid after fourth or sixth write, at target address
// R14: poll bit reads 0 during erase, 1 after
// R15: program to protected sector is ignored by device
// R16: all-protected erase: poll 0, toggle runs briefly, nothing erased
// R17: toggle bit inverts on each read while internal write runs
// R18: failure bit 0 normally, 1 on program or erase failure
// R19: program failure on 0 to 1 change or internal time-out
// R20: failure bit clears only with reset instruction
// R21: erase-window bit 0 during window, 1 after expiry or new sector code
// R22: status read bits 7,6,5,3 are poll, toggle, failure, window
// R23: reset instruction F0 returns to read mode; sent after id or failure
// R24: bypass entered with 20; program is A0 plus write; exit 90 then 00
// R25: only low twelve address bits matter for instruction matching
// R26: added sector erase code within window extends erase set
// R27: byte program is two unlocks, A0 at 555, then address/data write
// R28: reads of busy flash give status rather than data
`timescale 1ns/1ps
`default_nettype none
`include "fid_defs.vh"
module fid_host #(
    parameter AW = 16
) (
    input  wire          core_clk,
    input  wire          sys_rst,
    input  wire [3:0]    wb_adr_i,
    input  wire [31:0]   wb_dat_i,
    input  wire [3:0]    wb_sel_i,
    input  wire          wb_we_i,
    input  wire          wb_cyc_i,
    input  wire          wb_stb_i,
    output reg  [31:0]   wb_dat_o,
    output reg           wb_ack_o,
    output reg  [AW-1:0] mem_addr,
    output reg  [7:0]    mem_dout,
    output reg           mem_doe,
    input  wire [7:0]    mem_din,
    output reg           write_strobe_pin_n,
    output reg           read_strobe_n,
    output reg  [7:0]    main_sector_selects,
    output reg  [3:0]    boot_sector_selects
);
// ------------------------------------------------------------
// state encoding
// ------------------------------------------------------------
localparam S_IDLE = 5'b00001;
localparam S_SET  = 5'b00010;
localparam S_STRB = 5'b00100;
localparam S_HOLD = 5'b01000;
localparam S_NEXT = 5'b10000;
// ------------------------------------------------------------
// registers
// ------------------------------------------------------------
reg  [4:0]    st_r;
reg  [3:0]    op_r;
reg  [2:0]    step_r;
reg  [2:0]    nstep_r;
reg  [3:0]    ph_r;
reg           busy_r;
reg  [AW-1:0] tgt_addr_r;
reg  [7:0]    tgt_data_r;
reg  [7:0]    main_sel_r;
reg  [3:0]    boot_sel_r;
reg  [7:0]    rd_data_r;
reg           is_rd;
reg  [11:0]   cyc_addr;
reg  [7:0]    cyc_data;
wire          wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
// ------------------------------------------------------------
// step table: which bus cycle each instruction step performs
// ------------------------------------------------------------
always @* begin
    is_rd    = 1'b0;
    cyc_addr = `FID_UNLK1_ADDR;
    cyc_data = `FID_UNLK1_DATA;
    nstep_r  = 3'd0;
    case (op_r)
        `FID_OP_READ: begin
            is_rd    = 1'b1; // R08
            cyc_addr = tgt_addr_r[11:0]; // R13
        end
        `FID_OP_RESET: begin
            cyc_data = `FID_CODE_RESET; // R23
        end
        `FID_OP_BYP_PROG: begin
            if (step_r == 3'd0) begin
                cyc_data = `FID_CODE_PROG; // R24
                nstep_r  = 3'd1;
            end else begin
                cyc_addr = tgt_addr_r[11:0];
                cyc_data = tgt_data_r;
            end
        end
        `FID_OP_BYP_EXIT: begin
            cyc_data = (step_r == 3'd0) ? `FID_CODE_ID : `FID_CODE_BYPX; // R24
            nstep_r  = (step_r == 3'd0) ? 3'd1 : 3'd0;
        end
        `FID_OP_ADD_SECT: begin
            cyc_addr = tgt_addr_r[11:0]; // R26
            cyc_data = `FID_CODE_SECT;
        end
        default: begin
            // R03 two unlock writes, then per-op continuation
            case (step_r)
                3'd0: begin
                    nstep_r = 3'd1;
                end
                3'd1: begin
                    cyc_addr = `FID_UNLK2_ADDR;
                    cyc_data = `FID_UNLK2_DATA;
                    nstep_r  = 3'd2;
                end
                3'd2: begin
                    nstep_r = 3'd3;
                    case (op_r)
                        `FID_OP_PROG:      cyc_data = `FID_CODE_PROG; // R27
                        `FID_OP_BYP_ENTER: begin
                            cyc_data = `FID_CODE_BYP; // R24
                            nstep_r  = 3'd0;
                        end
                        `FID_OP_IDENT:     cyc_data = `FID_CODE_ID;
                        `FID_OP_PROT:      cyc_data = `FID_CODE_ID;
                        default:           cyc_data = `FID_CODE_ERASE;
                    endcase
                end
                3'd3: begin
                    case (op_r)
                        `FID_OP_PROG: begin
                            cyc_addr = tgt_addr_r[11:0];
                            cyc_data = tgt_data_r;
                        end
                        `FID_OP_IDENT: begin
                            is_rd    = 1'b1;
                            cyc_addr = `FID_ID_ADDR; // R09
                        end
                        `FID_OP_PROT: begin
                            is_rd    = 1'b1;
                            cyc_addr = `FID_PROT_ADDR; // R10
                        end
                        default: begin
                            cyc_addr = `FID_UNLK2_ADDR;
                            nstep_r  = 3'd4;
                        end
                    endcase
                end
                3'd4: begin
                    cyc_addr = `FID_UNLK2_ADDR;
                    cyc_data = `FID_UNLK2_DATA;
                    nstep_r  = 3'd5;
                end
                default: begin
                    if (op_r == `FID_OP_BULK_ER) begin
                        cyc_data = `FID_CODE_BULK;
                    end else begin
                        cyc_addr = tgt_addr_r[11:0];
                        cyc_data = `FID_CODE_SECT;
                    end
                end
            endcase
        end
    endcase
end
// ------------------------------------------------------------
// wishbone slave and bus sequencer
// ------------------------------------------------------------
always @(posedge core_clk) begin
    if (sys_rst) begin
        st_r                <= S_IDLE;
        op_r                <= `FID_OP_READ;
        step_r              <= 3'd0;
        ph_r                <= 4'h0;
        busy_r              <= 1'b0;
        tgt_addr_r          <= {AW{1'b0}};
        tgt_data_r          <= 8'h00;
        main_sel_r          <= 8'h01;
        boot_sel_r          <= 4'h0;
        rd_data_r           <= 8'h00;
        wb_dat_o            <= 32'h0000_0000;
        wb_ack_o            <= 1'b0;
        mem_addr            <= {AW{1'b0}};
        mem_dout            <= 8'h00;
        mem_doe             <= 1'b0;
        write_strobe_pin_n  <= 1'b1; // R07
        read_strobe_n       <= 1'b1;
        main_sector_selects <= 8'h00; // R07
        boot_sector_selects <= 4'h0;
    end else begin
        wb_ack_o <= 1'b0;
        if (wb_req) begin
            wb_ack_o <= 1'b1;
            wb_dat_o <= 32'h0000_0000;
            if (wb_we_i) begin
                case (wb_adr_i)
                    `FID_REG_CMD: begin
                        if (!busy_r && wb_sel_i[0]) begin
                            op_r   <= wb_dat_i[3:0];
                            step_r <= 3'd0;
                            busy_r <= 1'b1;
                            st_r   <= S_SET;
                        end
                    end
                    `FID_REG_ADDR: begin
                        if (!busy_r) begin
                            tgt_addr_r <= wb_dat_i[AW-1:0];
                        end
                    end
                    `FID_REG_DATA: begin
                        if (!busy_r) begin
                            tgt_data_r <= wb_dat_i[7:0];
                            main_sel_r <= wb_dat_i[15:8];  // R05
                            boot_sel_r <= wb_dat_i[19:16]; // R05
                        end
                    end
                    default: begin
                    end
                endcase
            end else begin
                case (wb_adr_i)
                    `FID_REG_CMD:    wb_dat_o <= {27'h0, busy_r, op_r};
                    `FID_REG_ADDR:   wb_dat_o <= {{(32-AW){1'b0}}, tgt_addr_r};
                    `FID_REG_DATA:   wb_dat_o <= {12'h000, boot_sel_r, main_sel_r,
                                                  tgt_data_r};
                    // R22 poll/toggle/failure/window keep their byte positions; bit 4 carries busy
                    `FID_REG_STATUS: wb_dat_o <= {24'h00_0000,
                                                  rd_data_r[`FID_BIT_POLL],
                                                  rd_data_r[`FID_BIT_TOGGLE],
                                                  rd_data_r[`FID_BIT_FAIL],
                                                  busy_r,
                                                  rd_data_r[`FID_BIT_WINDOW],
                                                  3'b000};
                    default:         wb_dat_o <= {24'h000000, rd_data_r};
                endcase
            end
        end
        case (st_r)
            S_IDLE: begin
                ph_r <= 4'h0;
            end
            S_SET: begin
                // R04 upper address lines zero, low lines carry the code address
                mem_addr            <= {{(AW-12){1'b0}}, cyc_addr}; // R25
                mem_dout            <= cyc_data;
                mem_doe             <= ~is_rd;
                main_sector_selects <= main_sel_r; // R04
                boot_sector_selects <= boot_sel_r;
                ph_r                <= 4'h0;
                st_r                <= S_STRB;
            end
            S_STRB: begin
                write_strobe_pin_n <= is_rd;
                read_strobe_n      <= ~is_rd;
                ph_r               <= ph_r + 4'h1;
                if (ph_r == `FID_PHASE_CYC) begin
                    ph_r <= 4'h0;
                    st_r <= S_HOLD;
                    if (is_rd) begin
                        rd_data_r <= mem_din; // R11 R28
                    end
                end
            end
            S_HOLD: begin
                write_strobe_pin_n <= 1'b1;
                read_strobe_n      <= 1'b1;
                st_r               <= S_NEXT;
            end
            S_NEXT: begin
                // R01 next byte follows within a few clocks
                mem_doe             <= 1'b0;
                main_sector_selects <= 8'h00;
                boot_sector_selects <= 4'h0;
                if (nstep_r != 3'd0) begin
                    step_r <= nstep_r;
                    st_r   <= S_SET;
                end else begin
                    busy_r <= 1'b0;
                    st_r   <= S_IDLE;
                end
            end
            default: begin
                st_r <= S_IDLE;
            end
        endcase
    end
end
endmodule
`default_nettype wire

// [inc/fid_defs.vh]
`ifndef FID_DEFS_VH
`define FID_DEFS_VH
// ------------------------------------------------------------
// wishbone register offsets (byte addresses)
// ------------------------------------------------------------
`define FID_REG_CMD      4'h0
`define FID_REG_ADDR     4'h4
`define FID_REG_DATA     4'h8
`define FID_REG_STATUS   4'hC
// ------------------------------------------------------------
// command codes written to the command register
// ------------------------------------------------------------
`define FID_OP_READ      4'h0
`define FID_OP_PROG      4'h1
`define FID_OP_SECT_ER   4'h2
`define FID_OP_BULK_ER   4'h3
`define FID_OP_RESET     4'h4
`define FID_OP_IDENT     4'h5
`define FID_OP_PROT      4'h6
`define FID_OP_BYP_ENTER 4'h7
`define FID_OP_BYP_PROG  4'h8
`define FID_OP_BYP_EXIT  4'h9
`define FID_OP_ADD_SECT  4'hA
// ------------------------------------------------------------
// instruction bytes and addresses
// ------------------------------------------------------------
`define FID_UNLK1_DATA   8'hAA
`define FID_UNLK2_DATA   8'h55
`define FID_UNLK1_ADDR   12'h555
`define FID_UNLK2_ADDR   12'hAAA
`define FID_CODE_PROG    8'hA0
`define FID_CODE_ERASE   8'h80
`define FID_CODE_SECT    8'h30
`define FID_CODE_BULK    8'h10
`define FID_CODE_RESET   8'hF0
`define FID_CODE_ID      8'h90
`define FID_CODE_BYP     8'h20
`define FID_CODE_BYPX    8'h00
`define FID_ID_ADDR      12'h001
`define FID_PROT_ADDR    12'h002
// ------------------------------------------------------------
// status bit positions on the data bus
// ------------------------------------------------------------
`define FID_BIT_POLL     7
`define FID_BIT_TOGGLE   6
`define FID_BIT_FAIL     5
`define FID_BIT_WINDOW   3
// ------------------------------------------------------------
// last strobe phase index; the strobe stays low this plus one core clocks
// ------------------------------------------------------------
`define FID_PHASE_CYC    4'h3
`endif

// [verification/fid_host_checker.sv]
`timescale 1ns/1ps
`default_nettype none
// ----
// host port checker
// ----
module fid_host_checker #(parameter AW = 16) (
    input wire logic          core_clk,
    input wire logic          sys_rst,
    input wire logic          wb_cyc_i,
    input wire logic          wb_stb_i,
    input wire logic          wb_ack_o,
    input wire logic [AW-1:0] mem_addr,
    input wire logic [7:0]    mem_dout,
    input wire logic          mem_doe,
    input wire logic          write_strobe_pin_n,
    input wire logic          read_strobe_n,
    input wire logic [7:0]    main_sector_selects,
    input wire logic [3:0]    boot_sector_selects
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    wire sel_any = |main_sector_selects || |boot_sector_selects;
    wire wr_lo   = !write_strobe_pin_n;
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    AST_ACK_ANSWER: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered");
    AST_IDLE_RST: assert property ($fell(sys_rst) |-> !wr_lo && read_strobe_n && !sel_any)
        else $error("bus not idle after reset");
    AST_WR_LEN: assert property ($fell(write_strobe_pin_n) |-> wr_lo [*4] ##1 !wr_lo)
        else $error("write strobe length wrong");
    AST_WR_SEL: assert property (wr_lo |-> sel_any && mem_doe)
        else $error("write without select or drive");
    AST_UPPER: assert property (wr_lo || !read_strobe_n |-> mem_addr[AW-1:12] == '0)
        else $error("upper address lines set");
    AST_WR_STABLE: assert property (wr_lo && !$past(write_strobe_pin_n)
        |-> $stable(mem_addr) && $stable(mem_dout)) else $error("write bus moved");
    AST_ONE_STROBE: assert property (read_strobe_n || !wr_lo)
        else $error("both strobes low");
    AST_RD_BUS: assert property (!read_strobe_n |-> !mem_doe && sel_any)
        else $error("read with drive or no select");
    cover property ($fell(write_strobe_pin_n));
    cover property ($fell(read_strobe_n));
    cover property (wb_ack_o);
endmodule
bind fid_host fid_host_checker #(.AW(AW)) u_chk (.core_clk(core_clk), .sys_rst(sys_rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .mem_addr(mem_addr),
    .mem_dout(mem_dout), .mem_doe(mem_doe), .write_strobe_pin_n(write_strobe_pin_n),
    .read_strobe_n(read_strobe_n), .main_sector_selects(main_sector_selects),
    .boot_sector_selects(boot_sector_selects));
`default_nettype wire

// [verification/fid_flash_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ----
// flash device model
// ----
module fid_flash_model #(
    parameter logic [7:0] ID_CODE   = 8'h5C, // arbitrary value
    parameter logic [7:0] PROT_MASK = 8'h02,
    parameter int         BUSY_RDS  = 2
) (
    input  wire logic [15:0] mem_addr,
    input  wire logic [7:0]  mem_dout,
    output logic [7:0]       mem_din,
    input  wire logic        write_strobe_pin_n,
    input  wire logic        read_strobe_n,
    input  wire logic [7:0]  main_sector_selects,
    input  wire logic [3:0]  boot_sector_selects
);
    logic [7:0]  mem [0:4095];
    logic [7:0]  out_r = 8'h00, pd_r = 8'h00, d;
    logic [2:0]  step_r = 3'h0;
    logic [1:0]  mode_r = 2'h0;
    logic        busy_r = 0, fail_r = 0, tog_r = 0, win_r = 1, ers_r = 0;
    int          left_r = 0;
    wire         sel  = |main_sector_selects || |boot_sector_selects;
    wire  [11:0] a    = mem_addr[11:0];
    wire         prot = |(main_sector_selects & PROT_MASK);
    initial foreach (mem[i]) mem[i] = 8'hFF;
    assign mem_din = (!read_strobe_n && sel) ? out_r : ~out_r;
    task automatic start(input logic e);
        busy_r <= 1'b1;
        ers_r  <= e;
        left_r <= BUSY_RDS;
    endtask
    always @(negedge read_strobe_n) if (sel) begin
        if (busy_r) begin
            out_r <= {ers_r ? 1'b0 : ~pd_r[7], ~tog_r, fail_r, 1'b0, win_r, 3'h0};
            tog_r  <= ~tog_r;
            left_r <= left_r - 1;
            if (left_r == 1 && !fail_r) begin
                busy_r <= 1'b0;
                win_r  <= 1'b1;
            end
        end else if (mode_r == 2'h1)
            out_r <= a[1] ? {7'h00, prot} : ID_CODE;
        else
            out_r <= mem[a];
    end
    always @(posedge write_strobe_pin_n) if (sel) begin
        d = mem_dout;
        if (d == 8'hF0 && mode_r != 2'h2) begin
            {mode_r, step_r, fail_r, busy_r} <= '0;
        end else if (busy_r && ers_r && !win_r && d == 8'h30) begin
            left_r <= BUSY_RDS;
            win_r  <= 1'b1;
        end else if (!busy_r) begin
            case (step_r)
                3'h0: if (mode_r == 2'h2) step_r <= d == 8'hA0 ? 3'h6 : d == 8'h90 ? 3'h7 : 3'h0;
                      else step_r <= 3'(d == 8'hAA && a == 12'h555);
                3'h1: step_r <= (d == 8'h55 && a == 12'hAAA) ? 3'h2 : 3'h0;
                3'h2: begin
                    step_r <= a != 12'h555 ? 3'h0 : d == 8'hA0 ? 3'h6 : d == 8'h80 ? 3'h3 : 3'h0;
                    if (a == 12'h555 && d == 8'h90) mode_r <= 2'h1;
                    if (a == 12'h555 && d == 8'h20) mode_r <= 2'h2;
                end
                3'h3: step_r <= d == 8'hAA ? 3'h4 : 3'h0;
                3'h4: step_r <= d == 8'h55 ? 3'h5 : 3'h0;
                3'h5: begin
                    step_r <= 3'h0;
                    if (d == 8'h30 || d == 8'h10) begin
                        start(1'b1);
                        win_r <= 1'b0;
                        if (!prot) foreach (mem[i]) mem[i] <= 8'hFF;
                    end
                end
                3'h6: begin
                    step_r <= 3'h0;
                    pd_r   <= d;
                    if (!prot) start(1'b0);
                    if (!prot) mem[a] <= mem[a] & d;
                    if (!prot && |(d & ~mem[a])) fail_r <= 1'b1;
                end
                3'h7: begin
                    step_r <= 3'h0;
                    if (d == 8'h00) mode_r <= 2'h0;
                end
                default: step_r <= 3'h0;
            endcase
        end
    end
endmodule
`default_nettype wire

// [verification/test_fid_host.sv]
`timescale 1ns/1ps
`default_nettype none
// ----
// host bench
// ----
module test_fid_host;
    localparam logic [7:0]  ID_VAL = 8'h5C; // arbitrary value
    localparam logic [11:0] M0     = 12'h001;
    logic        core_clk = 1'b0;
    logic        sys_rst  = 1'b1;
    logic        wb_we_i  = 1'b0;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic [3:0]  wb_adr_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o, q;
    logic        wb_ack_o, mem_doe, wr_n, rd_n;
    logic [15:0] mem_addr;
    logic [7:0]  mem_dout, mem_din, msel;
    logic [3:0]  bsel;
    int          num_errors = 0;
    int          tests_run  = 0;
    always #5 core_clk = ~core_clk;
    fid_host u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_sel_i(4'hF), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_addr(mem_addr),
        .mem_dout(mem_dout), .mem_doe(mem_doe), .mem_din(mem_din), .write_strobe_pin_n(wr_n),
        .read_strobe_n(rd_n), .main_sector_selects(msel), .boot_sector_selects(bsel));
    fid_flash_model #(.ID_CODE(ID_VAL)) u_mdl (.mem_addr(mem_addr), .mem_dout(mem_dout),
        .mem_din(mem_din), .write_strobe_pin_n(wr_n), .read_strobe_n(rd_n),
        .main_sector_selects(msel), .boot_sector_selects(bsel));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wbx(input logic we, input logic [3:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge core_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, adr, dat};
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        chk("ack", {31'h0000_0000, wb_ack_o}, 32'h0000_0001);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
    endtask
    task automatic op(input logic [3:0] c, input logic [11:0] a, input logic [7:0] d,
                      input logic [11:0] s);
        int n;
        n = 0;
        wbx(1'b1, 4'h4, {20'h0_0000, a});
        wbx(1'b1, 4'h8, {12'h000, s, d});
        wbx(1'b1, 4'h0, {28'h000_0000, c});
        do begin
            wbx(1'b0, 4'h0, 32'h0000_0000);
            n++;
        end while (q[4] !== 1'b0 && n < 40);
        chk("busy", {31'h0000_0000, q[4]}, 32'h0000_0000);
    endtask
    task automatic lchk(input string nm, input logic [7:0] m, input logic [7:0] e);
        wbx(1'b0, 4'h2, 32'h0000_0000);
        chk(nm, {24'h00_0000, q[7:0] & m}, {24'h00_0000, e});
    endtask
    task automatic rchk(input string nm, input logic [11:0] a, input logic [7:0] m,
                        input logic [7:0] e);
        op(4'h0, a, 8'h00, M0);
        lchk(nm, m, e);
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #200_000;
        num_errors++;
        stop_test;
    end
    initial begin
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        u_mdl.mem[12'h123] = 8'h5A;
        wbx(1'b0, 4'h8, 32'h0000_0000);
        chk("data_reset", q, 32'h0000_0100);
        rchk("plain", 12'h123, 8'hFF, 8'h5A);
        op(4'h1, 12'h010, 8'h3C, M0);
        rchk("poll_prog", 12'h010, 8'hE8, 8'hC8);
        wbx(1'b0, 4'hC, 32'h0000_0000);
        chk("status", q, 32'h0000_00C8);
        rchk("toggle", 12'h010, 8'hE8, 8'h88);
        rchk("prog_done", 12'h010, 8'hFF, 8'h3C);
        op(4'h1, 12'h010, 8'hC3, M0);
        rchk("fail", 12'h010, 8'h20, 8'h20);
        rchk("fail_held", 12'h010, 8'h20, 8'h20);
        op(4'h4, 12'h000, 8'h00, M0);
        rchk("fail_clr", 12'h010, 8'hFF, 8'h00);
        op(4'h5, 12'h001, 8'h00, M0);
        lchk("ident", 8'hFF, ID_VAL);
        op(4'h4, 12'h000, 8'h00, M0);
        op(4'h6, 12'h002, 8'h00, 12'h002);
        lchk("prot_set", 8'hFF, 8'h01);
        op(4'h4, 12'h000, 8'h00, M0);
        op(4'h6, 12'h002, 8'h00, M0);
        lchk("prot_clr", 8'hFF, 8'h00);
        op(4'h4, 12'h000, 8'h00, M0);
        op(4'h1, 12'h020, 8'h00, 12'h002);
        rchk("prot_prog", 12'h020, 8'hFF, 8'hFF);
        op(4'h7, 12'h000, 8'h00, M0);
        op(4'h8, 12'h030, 8'h77, M0);
        rchk("byp_poll", 12'h030, 8'h80, 8'h80);
        rchk("byp_poll2", 12'h030, 8'h80, 8'h80);
        rchk("byp_done", 12'h030, 8'hFF, 8'h77);
        op(4'h9, 12'h000, 8'h00, M0);
        rchk("byp_exit", 12'h123, 8'hFF, 8'h5A);
        for (int i = 2; i < 4; i++) begin
            op(4'(i), 12'h100, 8'h00, M0);
            rchk("erase_poll", 12'h123, 8'hA8, 8'h00);
            if (i == 2) begin
                op(4'hA, 12'h100, 8'h00, M0);
                rchk("erase_add", 12'h123, 8'hA8, 8'h08);
            end
            rchk("erase_poll2", 12'h123, 8'hA8, (i == 2) ? 8'h08 : 8'h00);
            rchk("erase_done", 12'h123, 8'hFF, 8'hFF);
        end
        stop_test;
    end
endmodule
`default_nettype wire
